// >>> core/serial_ctrl_cfg.svh
// serial_ctrl_cfg.svh: offsets, field positions, resets, counts
// assumes: included by bare name from the core files
`ifndef SERIAL_CTRL_CFG_SVH
`define SERIAL_CTRL_CFG_SVH
// ****************************************
// register offsets
// ****************************************
`define OFS_CONTROL_ONE   2'h0
`define OFS_CONTROL_TWO   2'h1
`define OFS_CONTROL_THREE 2'h2
// ****************************************
// control one fields
// ****************************************
`define B_LOOP_SELECT   7
`define B_STOP_IN_WAIT  6
`define B_RX_SOURCE     5
`define B_NINE_BIT      4
`define B_WAKE_METHOD   3
`define B_IDLE_TYPE     2
`define B_PARITY_EN     1
`define B_PARITY_TYPE   0
// ****************************************
// control two fields
// ****************************************
`define B_TX_EMPTY_IE   7
`define B_TX_DONE_IE    6
`define B_RX_FULL_IE    5
`define B_IDLE_IE       4
`define B_TX_ENABLE     3
`define B_RX_ENABLE     2
`define B_RX_WAKEUP     1
`define B_SEND_BREAK    0
// ****************************************
// control three fields
// ****************************************
`define B_LONG_BREAK    1
`define B_WIRE_DIR      0
// ****************************************
// reset values and bit-time counts
// ****************************************
`define RST_CONTROL     8'h00
`define IDLE_BITS_8     4'hA
`define IDLE_BITS_9     4'hB
`define BREAK_BITS_8    4'hA
`define BREAK_BITS_9    4'hB
`define LBREAK_BITS_8   4'hD
`define LBREAK_BITS_9   4'hE
`endif

// >>> core/serial_ctrl_pkg.sv
// serial_ctrl_pkg.sv: state type of the control block
// assumes: nothing beyond the compiler
package serial_ctrl_pkg;
   typedef struct packed
   {
      logic [7:0] ctl1;
      logic [7:0] ctl2;
      logic [7:0] ctl3;
      logic [7:0] rd_data;
      logic       irq;
      logic       txd_out;
      logic       txd_oe_n;
      logic       rx_in;
      logic       rxd_owned;
      logic       tx_owned;
      logic       clk_run;
      logic       queue_idle;
      logic       break_once;
      logic       tx_parity;
      logic       rx_perr;
      logic [3:0] idle_bits;
      logic [3:0] break_bits;
   } ctl_state_s;
endpackage

// >>> core/uart_control_registers.sv
// uart_control_registers.sv: control registers, pin routing, irq
// assumes: shifters, baud divider and flags live outside
//
// How it works
// - loop select feeds transmitter into receiver
// - source select ignored while loop clear
// - source set: single wire on tx pin
// - stop-in-wait freezes clocks during wait
// - nine-bit bit adds ninth data bit
// - wake method: idle or address mark
// - idle count start, 10 or 11 bits
// - parity uses the top data bit
// - parity type even 0, odd 1
// - empty flag with enable raises irq
// - complete flag with enable raises irq
// - full flag with enable raises irq
// - idle flag with enable raises irq
// - tx enable drives tx pin out
// - single wire direction picks drive or receive
// - enable off then on queues idle
// - pin kept until pending work done
// - rx pin freed when off or looped
// - wakeup bit set by sw, hw clears
// - send break queues break characters
//
// Strobed register access and the address map were decided locally.
`include "serial_ctrl_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
module uart_control_registers
#(
   parameter int ADDR_W = 2
)
(
   // clock and reset
   input  wire logic              i_clk,
   input  wire logic              i_sys_rst,
   // register port
   input  wire logic [ADDR_W-1:0] i_addr,
   input  wire logic [7:0]        i_wr_data,
   input  wire logic              i_wr_stb,
   input  wire logic              i_rd_stb,
   output logic      [7:0]        o_rd_data,
   // status flags from the core
   input  wire logic              i_tx_empty,
   input  wire logic              i_tx_done,
   input  wire logic              i_rx_full,
   input  wire logic              i_idle_flag,
   input  wire logic              i_wakeup_seen,
   input  wire logic              i_tx_busy,
   input  wire logic              i_cpu_wait,
   // shifter data
   input  wire logic              i_tx_serial,
   input  wire logic [8:0]        i_tx_char,
   input  wire logic [8:0]        i_rx_char,
   // pins
   input  wire logic              i_txd_pin,
   input  wire logic              i_rxd_pin,
   output logic                   o_txd_pin,
   output logic                   o_txd_oe_n,
   output logic                   o_rxd_owned,
   // to the core
   output logic                   o_rx_serial,
   output logic                   o_tx_on,
   output logic                   o_rx_on,
   output logic                   o_nine_bit,
   output logic                   o_wake_mark,
   output logic                   o_idle_after_stop,
   output logic                   o_rx_standby,
   output logic                   o_break_level,
   output logic                   o_break_once,
   output logic                   o_queue_idle,
   output logic                   o_clk_run,
   output logic                   o_tx_parity,
   output logic                   o_rx_perr,
   output logic      [3:0]        o_idle_bits,
   output logic      [3:0]        o_break_bits,
   output logic                   o_irq
);

   // ****************************************
   // elaboration check
   // ****************************************
   if (ADDR_W < 2)
   begin : g_bad
      $error("ADDR_W must be at least 2");
   end

   // ****************************************
   // state
   // ****************************************
   serial_ctrl_pkg::ctl_state_s st;
   serial_ctrl_pkg::ctl_state_s next_st;

   logic [7:0] next_c1;
   logic [7:0] next_c2;
   logic       loop_select;
   logic       single_wire;
   logic       wr1;
   logic       wr2;

   // ones count of the character, parity slot optional
   function automatic logic ones_odd
   (
      input logic [8:0] c,
      input logic       nine,
      input logic       with_top
   );
      logic [8:0] m;
      m = nine ? 9'h0FF : 9'h07F;
      if (with_top)
      begin
         m = nine ? 9'h1FF : 9'h0FF;
      end
      return ^(c & m);
   endfunction

   // write address decode for control one and two
   assign wr1 = i_wr_stb && (i_addr == ADDR_W'(`OFS_CONTROL_ONE));
   assign wr2 = i_wr_stb && (i_addr == ADDR_W'(`OFS_CONTROL_TWO));

   // ****************************************
   // next state
   // ****************************************
   always_comb
   begin
      next_st = st;
      next_c1 = st.ctl1;
      next_c2 = st.ctl2;
      // register writes take effect next clock
      if (wr1)
      begin
         next_c1 = i_wr_data;
      end
      if (wr2)
      begin
         next_c2 = i_wr_data;
      end
      // hw clears wakeup, a sw set in that cycle wins
      if (i_wakeup_seen && st.ctl2[`B_RX_WAKEUP]
          && !(wr2 && i_wr_data[`B_RX_WAKEUP]))
      begin
         next_c2[`B_RX_WAKEUP] = 1'b0;
      end
      next_st.ctl1 = next_c1;
      next_st.ctl2 = next_c2;
      if (i_wr_stb && (i_addr == ADDR_W'(`OFS_CONTROL_THREE)))
      begin
         next_st.ctl3 = {6'h00, i_wr_data[1:0]};
      end
      // read data stand the cycle after the strobe
      next_st.rd_data = 8'h00;
      if (i_rd_stb)
      begin
         case (i_addr)
            ADDR_W'(`OFS_CONTROL_ONE):   next_st.rd_data = st.ctl1;
            ADDR_W'(`OFS_CONTROL_TWO):   next_st.rd_data = st.ctl2;
            ADDR_W'(`OFS_CONTROL_THREE):
               next_st.rd_data = {5'h00, st.tx_owned, st.ctl3[1:0]};
            default:                     next_st.rd_data = 8'h00;
         endcase
      end
      // enable off then on queues an idle
      next_st.queue_idle = wr2 && !st.ctl2[`B_TX_ENABLE]
                           && i_wr_data[`B_TX_ENABLE];
      // a one then zero on send break queues one break
      next_st.break_once = wr2 && st.ctl2[`B_SEND_BREAK]
                           && !i_wr_data[`B_SEND_BREAK];
      // pin held while enabled or work pending
      next_st.tx_owned = next_c2[`B_TX_ENABLE] || i_tx_busy
                         || next_st.queue_idle
                         || next_st.break_once;
      // combined level interrupt
      next_st.irq = (i_tx_empty  && next_c2[`B_TX_EMPTY_IE])
                 || (i_tx_done   && next_c2[`B_TX_DONE_IE])
                 || (i_rx_full   && next_c2[`B_RX_FULL_IE])
                 || (i_idle_flag && next_c2[`B_IDLE_IE]);
      // wait mode clock freeze
      next_st.clk_run = !(i_cpu_wait
                          && next_c1[`B_STOP_IN_WAIT]);
      // parity generate and check
      next_st.tx_parity = next_c1[`B_PARITY_EN]
         && (ones_odd(i_tx_char, next_c1[`B_NINE_BIT], 1'b0)
             ^ next_c1[`B_PARITY_TYPE]);
      next_st.rx_perr = next_c1[`B_PARITY_EN]
         && (ones_odd(i_rx_char, next_c1[`B_NINE_BIT], 1'b1)
             != next_c1[`B_PARITY_TYPE]);
      // idle and break lengths in bit times
      next_st.idle_bits = next_c1[`B_NINE_BIT] ? `IDLE_BITS_9
                                               : `IDLE_BITS_8;
      if (next_st.ctl3[`B_LONG_BREAK])
      begin
         next_st.break_bits = next_c1[`B_NINE_BIT] ? `LBREAK_BITS_9
                                                   : `LBREAK_BITS_8;
      end
      else
      begin
         next_st.break_bits = next_c1[`B_NINE_BIT] ? `BREAK_BITS_9
                                                   : `BREAK_BITS_8;
      end
      // pin routing
      next_st.txd_out = i_tx_serial;
      next_st.txd_oe_n = !next_st.tx_owned;
      if (next_c1[`B_LOOP_SELECT] && next_c1[`B_RX_SOURCE]
          && !next_st.ctl3[`B_WIRE_DIR])
      begin
         next_st.txd_oe_n = 1'b1;
      end
      if (!next_c1[`B_LOOP_SELECT])
      begin
         next_st.rx_in = i_rxd_pin;
      end
      else if (next_c1[`B_RX_SOURCE])
      begin
         next_st.rx_in = i_txd_pin;
      end
      else
      begin
         next_st.rx_in = i_tx_serial;
      end
      next_st.rxd_owned = next_c2[`B_RX_ENABLE]
                          && !next_c1[`B_LOOP_SELECT];
   end

   // ****************************************
   // registers
   // ****************************************
   always_ff @(posedge i_clk)
   begin
      if (i_sys_rst)
      begin
         st <= '0;
         st.ctl1 <= `RST_CONTROL;
         st.ctl2 <= `RST_CONTROL;
         st.txd_out <= 1'b1;
         st.txd_oe_n <= 1'b1;
         st.rx_in <= 1'b1;
         st.clk_run <= 1'b1;
         st.idle_bits <= `IDLE_BITS_8;
         st.break_bits <= `BREAK_BITS_8;
      end
      else
      begin
         st <= next_st;
      end
   end

   // ****************************************
   // outputs
   // ****************************************
   assign loop_select = st.ctl1[`B_LOOP_SELECT];
   assign single_wire = loop_select && st.ctl1[`B_RX_SOURCE];
   assign o_rd_data = st.rd_data;
   assign o_txd_pin = st.txd_out;
   assign o_txd_oe_n = st.txd_oe_n;
   assign o_rxd_owned = st.rxd_owned;
   assign o_rx_serial = st.rx_in;
   assign o_tx_on = st.ctl2[`B_TX_ENABLE];
   assign o_rx_on = st.ctl2[`B_RX_ENABLE];
   assign o_nine_bit = st.ctl1[`B_NINE_BIT];
   assign o_wake_mark = st.ctl1[`B_WAKE_METHOD];
   assign o_idle_after_stop = st.ctl1[`B_IDLE_TYPE];
   assign o_rx_standby = st.ctl2[`B_RX_WAKEUP];
   assign o_break_level = st.ctl2[`B_SEND_BREAK];
   assign o_break_once = st.break_once;
   assign o_queue_idle = st.queue_idle;
   assign o_clk_run = st.clk_run;
   assign o_tx_parity = st.tx_parity;
   assign o_rx_perr = st.rx_perr;
   assign o_idle_bits = st.idle_bits;
   assign o_break_bits = st.break_bits;
   assign o_irq = st.irq;

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_sys_rst);

   chk_loop_route: assert property (
      loop_select && !st.ctl1[`B_RX_SOURCE] && $past(loop_select)
      && !$past(st.ctl1[`B_RX_SOURCE]) |-> o_rx_serial == $past(i_tx_serial))
      else $error("loop route wrong");

   chk_normal_rx: assert property (
      !loop_select && !$past(loop_select) |-> o_rx_serial == $past(i_rxd_pin))
      else $error("rx pin not routed");

   chk_wire_rx: assert property (
      single_wire && $past(single_wire) |-> o_rx_serial == $past(i_txd_pin))
      else $error("single wire rx wrong");

   chk_wait_clk: assert property (
      i_cpu_wait && st.ctl1[`B_STOP_IN_WAIT] && !wr1 |=> !o_clk_run)
      else $error("clocks not frozen");

   chk_irq_level: assert property (
      i_rx_full && st.ctl2[`B_RX_FULL_IE] && !wr2 |=> o_irq)
      else $error("irq missing");

   chk_irq_quiet: assert property (
      st.ctl2[7:4] == 4'h0 && !wr2 |=> !o_irq)
      else $error("irq without enable");

   chk_idle_queue: assert property (
      wr2 && !st.ctl2[`B_TX_ENABLE] && i_wr_data[`B_TX_ENABLE]
      |=> o_queue_idle ##1 !o_queue_idle)
      else $error("idle not queued once");

   chk_pin_hold: assert property (
      i_tx_busy && !(st.ctl1[`B_LOOP_SELECT] && st.ctl1[`B_RX_SOURCE])
      && !wr1 |=> !o_txd_oe_n)
      else $error("pin released early");

   chk_rx_free: assert property (
      loop_select && !wr1 |=> !o_rxd_owned)
      else $error("rx pin kept in loop");

   chk_wake_clr: assert property (
      i_wakeup_seen && !wr2 |=> !o_rx_standby)
      else $error("wakeup not cleared");

   chk_read_data: assert property (
      i_rd_stb && i_addr == ADDR_W'(`OFS_CONTROL_ONE) && !$past(wr1)
      |=> o_rd_data == $past(st.ctl1))
      else $error("read data wrong");

endmodule
`default_nettype wire

// >>> dv/serial_node_model.sv
// serial_node_model.sv: remote serial node on the txd and rxd wires
// assumes: bench sets what the node sends; both wires have pull-ups
`timescale 1ns/10ps
`default_nettype none
module serial_node_model
(
   // node side
   input  wire logic i_node_bit,
   input  wire logic i_node_drive,
   // block pins
   input  wire logic i_txd_pin,
   input  wire logic i_txd_oe_n,
   // resolved wire levels
   output logic      o_txd_line,
   output logic      o_rxd_line
);
   // ****************************************
   // wire resolution
   // ****************************************
   // released rxd floats to its pull-up
   assign o_rxd_line = i_node_drive ? i_node_bit : 1'b1;
   // shared line: block wins while it drives, else node or pull-up
   assign o_txd_line = !i_txd_oe_n ? i_txd_pin : (i_node_drive ? i_node_bit : 1'b1);
endmodule
`default_nettype wire

// >>> dv/uart_control_registers_tb.sv
// uart_control_registers_tb.sv: register-level bench of the control block
// assumes: serial_ctrl_pkg compiled, cfg header on the include path
`timescale 1ns/10ps
`default_nettype none
module uart_control_registers_tb;
   logic       i_clk, i_sys_rst, i_wr_stb, i_rd_stb;
   logic [1:0] i_addr;
   logic [7:0] i_wr_data, o_rd_data;
   logic       i_tx_empty, i_tx_done, i_rx_full, i_idle_flag, i_wakeup_seen, i_tx_busy, i_cpu_wait, i_tx_serial;
   logic [8:0] i_tx_char, i_rx_char;
   logic       i_txd_pin, i_rxd_pin, o_txd_pin, o_txd_oe_n, o_rxd_owned, o_rx_serial, o_tx_on, o_rx_on;
   logic       o_nine_bit, o_wake_mark, o_idle_after_stop, o_rx_standby, o_break_level, o_break_once;
   logic       o_queue_idle, o_clk_run, o_tx_parity, o_rx_perr, o_irq, node_bit, node_drive;
   logic [3:0] o_idle_bits, o_break_bits;
   int         failures, comparisons;
   logic [7:0] pc  [5] = '{8'h02, 8'h03, 8'h00, 8'h12, 8'h13};
   logic [8:0] ptx [5] = '{9'h007, 9'h007, 9'h007, 9'h0FE, 9'h0FE};
   logic [8:0] prx [5] = '{9'h003, 9'h003, 9'h001, 9'h100, 9'h100};
   logic [1:0] pexp[5] = '{2'h2, 2'h1, 2'h0, 2'h3, 2'h0};

   uart_control_registers dut (.i_clk, .i_sys_rst, .i_addr, .i_wr_data, .i_wr_stb, .i_rd_stb, .o_rd_data,
      .i_tx_empty, .i_tx_done, .i_rx_full, .i_idle_flag, .i_wakeup_seen, .i_tx_busy, .i_cpu_wait,
      .i_tx_serial, .i_tx_char, .i_rx_char, .i_txd_pin, .i_rxd_pin, .o_txd_pin, .o_txd_oe_n, .o_rxd_owned,
      .o_rx_serial, .o_tx_on, .o_rx_on, .o_nine_bit, .o_wake_mark, .o_idle_after_stop, .o_rx_standby,
      .o_break_level, .o_break_once, .o_queue_idle, .o_clk_run, .o_tx_parity, .o_rx_perr, .o_idle_bits,
      .o_break_bits, .o_irq);
   serial_node_model node (.i_node_bit(node_bit), .i_node_drive(node_drive), .i_txd_pin(o_txd_pin),
      .i_txd_oe_n(o_txd_oe_n), .o_txd_line(i_txd_pin), .o_rxd_line(i_rxd_pin));

   // ****************************************
   // access and compare tasks
   // ****************************************
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         failures++;
         $display("ERROR t=%0t seen=%h expected=%h", $time, got, exp);
      end
   endtask
   // one write cycle, returns just after the taking edge
   task automatic wr(input logic [1:0] a, input logic [7:0] d);
      @(posedge i_clk);
      i_addr    <= a;
      i_wr_data <= d;
      i_wr_stb  <= 1'b1;
      @(posedge i_clk);
      i_wr_stb  <= 1'b0;
      #1;
   endtask
   // one read cycle, data looked at in the cycle after the strobe
   task automatic rd(input logic [1:0] a, input logic [7:0] exp);
      @(posedge i_clk);
      i_addr   <= a;
      i_rd_stb <= 1'b1;
      @(posedge i_clk);
      i_rd_stb <= 1'b0;
      #1;
      chk(o_rd_data, exp);
   endtask
   // let one edge land after an input change
   task automatic nxt;
      @(posedge i_clk);
      #1;
   endtask
   task automatic summarize;
      $display("comparisons=%0d failures=%0d", comparisons, failures);
      if (failures == 0 && comparisons > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // ****************************************
   // clock, watchdog and sequence
   // ****************************************
   initial
   begin
      i_clk = 1'b0;
      forever #20 i_clk = ~i_clk;
   end
   // hang guard
   initial
   begin
      repeat (5000) @(posedge i_clk);
      failures++;
      summarize();
   end
   initial
   begin
      failures = 0;
      comparisons = 0;
      i_sys_rst = 1'b1;
      {i_wr_stb, i_rd_stb, i_addr, i_wr_data} = '0;
      {i_tx_empty, i_tx_done, i_rx_full, i_idle_flag, i_wakeup_seen, i_tx_busy, i_cpu_wait} = '0;
      {i_tx_serial, node_bit, node_drive, i_tx_char, i_rx_char} = {1'b1, 2'h0, 18'h0};
      repeat (3) @(posedge i_clk);
      i_sys_rst <= 1'b0;
      // reset values and unmapped offset
      rd(2'h0, 8'h00);
      rd(2'h1, 8'h00);
      rd(2'h2, 8'h00);
      rd(2'h3, 8'h00);
      chk(8'(o_txd_oe_n), 8'h01);
      chk(8'(o_idle_bits), 8'h0A);
      wr(2'h0, 8'hA5);
      rd(2'h0, 8'hA5);
      // source select without loop keeps the rxd pin
      wr(2'h0, 8'h20);
      wr(2'h1, 8'h04);
      chk(8'(o_rx_on), 8'h01);
      @(posedge i_clk);
      node_drive <= 1'b1;
      nxt();
      nxt();
      chk(8'(o_rx_serial), 8'h00);
      chk(8'(o_rxd_owned), 8'h01);
      // plain loop: transmitter feeds receiver, rxd freed
      @(posedge i_clk);
      node_bit    <= 1'b1;
      i_tx_serial <= 1'b0;
      wr(2'h0, 8'h80);
      nxt();
      chk(8'(o_rx_serial), 8'h00);
      chk(8'(o_rxd_owned), 8'h00);
      // single wire, receiving: node drives the shared line
      @(posedge i_clk);
      node_bit    <= 1'b0;
      i_tx_serial <= 1'b1;
      wr(2'h1, 8'h0C);
      chk(8'(o_tx_on), 8'h01);
      wr(2'h0, 8'hA0);
      nxt();
      nxt();
      chk(8'(o_txd_oe_n), 8'h01);
      chk(8'(o_rx_serial), 8'h00);
      // single wire, driving
      @(posedge i_clk);
      node_drive  <= 1'b0;
      i_tx_serial <= 1'b0;
      wr(2'h2, 8'h01);
      nxt();
      chk(8'(o_txd_oe_n), 8'h00);
      chk(8'(o_txd_pin), 8'h00);
      nxt();
      chk(8'(o_rx_serial), 8'h00);
      // enable toggling, queued idle and pin hold while busy
      wr(2'h2, 8'h00);
      wr(2'h0, 8'h00);
      wr(2'h1, 8'h00);
      @(posedge i_clk);
      i_tx_busy <= 1'b1;
      wr(2'h1, 8'h08);
      chk(8'(o_queue_idle), 8'h01);
      nxt();
      chk(8'(o_queue_idle), 8'h00);
      chk(8'(o_txd_oe_n), 8'h00);
      rd(2'h2, 8'h04);
      wr(2'h1, 8'h00);
      nxt();
      chk(8'(o_txd_oe_n), 8'h00);
      chk(8'(o_tx_on), 8'h00);
      @(posedge i_clk);
      i_tx_busy <= 1'b0;
      nxt();
      chk(8'(o_txd_oe_n), 8'h01);
      // break queuing and lengths
      wr(2'h1, 8'h01);
      chk(8'(o_break_level), 8'h01);
      wr(2'h2, 8'h02);
      chk(8'(o_break_bits), 8'h0D);
      wr(2'h0, 8'h10);
      chk(8'(o_break_bits), 8'h0E);
      chk(8'(o_idle_bits), 8'h0B);
      chk(8'(o_nine_bit), 8'h01);
      wr(2'h1, 8'h00);
      chk(8'(o_break_once), 8'h01);
      nxt();
      chk(8'(o_break_once), 8'h00);
      // wake method and idle count start
      wr(2'h0, 8'h0C);
      chk(8'(o_wake_mark), 8'h01);
      chk(8'(o_idle_after_stop), 8'h01);
      // clock freeze in wait
      wr(2'h0, 8'h40);
      @(posedge i_clk);
      i_cpu_wait <= 1'b1;
      nxt();
      chk(8'(o_clk_run), 8'h00);
      wr(2'h0, 8'h00);
      chk(8'(o_clk_run), 8'h01);
      // standby set by software, cleared by wakeup
      wr(2'h1, 8'h02);
      chk(8'(o_rx_standby), 8'h01);
      @(posedge i_clk);
      i_wakeup_seen <= 1'b1;
      @(posedge i_clk);
      i_wakeup_seen <= 1'b0;
      #1;
      chk(8'(o_rx_standby), 8'h00);
      rd(2'h1, 8'h00);
      // parity generation and checking table
      for (int k = 0; k < 5; k++)
      begin
         @(posedge i_clk);
         i_tx_char <= ptx[k];
         i_rx_char <= prx[k];
         wr(2'h0, pc[k]);
         chk(8'({o_tx_parity, o_rx_perr}), 8'(pexp[k]));
      end
      // each interrupt source alone, then the other three masked
      for (int k = 0; k < 4; k++)
      begin
         wr(2'h1, 8'h80 >> k);
         @(posedge i_clk);
         {i_tx_empty, i_tx_done, i_rx_full, i_idle_flag} <= 4'h8 >> k;
         nxt();
         chk(8'(o_irq), 8'h01);
         @(posedge i_clk);
         {i_tx_empty, i_tx_done, i_rx_full, i_idle_flag} <= ~(4'h8 >> k);
         nxt();
         chk(8'(o_irq), 8'h00);
      end
      summarize();
   end
endmodule
`default_nettype wire
